// File: rtl/rco_map.vh
`ifndef RCO_MAP_VH
`define RCO_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RCO_IDX_PERIPH_OFF0   12'h10c
`define RCO_IDX_CONTROL       12'h296
`define RCO_IDX_SOURCE_SEL    12'h297
`define RCO_IDX_STATUS        12'h298

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCO_CTRL_EN_BIT       7
`define RCO_CTRL_DUTY_HI      4
`define RCO_CTRL_DUTY_LO      3
`define RCO_CTRL_DIV_HI       2
`define RCO_CTRL_DIV_LO       0
`define RCO_PMD_OFF_BIT       6
`define RCO_SRC_HI            3
`define RCO_SRC_LO            0
`define RCO_STAT_RUN_BIT      0
`define RCO_STAT_OUT_BIT      1
`define RCO_STAT_HALT_BIT     2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCO_CTRL_RST          8'h10
`define RCO_EN_RST            1'b0
`define RCO_DUTY_RST          2'h2
`define RCO_DIV_RST           3'h0
`define RCO_SRC_RST           4'h0
`define RCO_PMD_RST           8'h00

// ----------------------------------------------------------------------
// Source codes and field values
// ----------------------------------------------------------------------
`define RCO_SRC_SYSOSC        4'h0
`define RCO_SRC_LAST_VALID    4'hb
`define RCO_DUTY_OFF          2'h0
`define RCO_DIV_NONE          3'h0

`endif

// File: rtl/rco_divider.v
`timescale 1ns/1ps
`include "rco_map.vh"

module rco_divider #(
  parameter CNT_W = 8
) (
  input  wire       i_clk_sys,  // System clock
  input  wire       i_resetn,   // Async reset, active low
  input  wire       i_enable,   // Effective module enable
  input  wire       i_rise,     // Rising edge of selected source
  input  wire       i_fall,     // Falling edge of selected source
  input  wire [2:0] i_div,      // Power-of-two ratio code
  input  wire [1:0] i_duty,     // Duty code
  output wire       o_clk_out,  // Divided output (registered)
  output wire       o_running   // Output active (registered)
);

  // ----------------------------------------------------------------------
  // Half-period arithmetic
  // ----------------------------------------------------------------------
  // Counting both source edges gives the quarter resolution 25% needs
  // at a ratio of two.
  function is_high;
    input [CNT_W-1:0] pos;
    input [2:0]       div;
    input [1:0]       duty;
    reg   [CNT_W:0]   thr;
    begin
      thr = ({{(CNT_W-1){1'b0}}, duty} << div) >> 1;
      if (duty == `RCO_DUTY_OFF)
        is_high = 1'b0;
      else if (div == `RCO_DIV_NONE)
        is_high = (pos == {CNT_W{1'b0}});
      else
        is_high = ({1'b0, pos} < thr);
    end
  endfunction

  reg  [CNT_W-1:0] cnt_ff;
  reg  [CNT_W-1:0] nxt_cnt;
  reg              run_ff;
  reg              nxt_run;
  reg              out_ff;
  reg              nxt_out;
  wire [CNT_W:0]   span;
  wire [CNT_W:0]   span_m1;
  wire [CNT_W-1:0] last_pos;
  wire [CNT_W-1:0] pos_now;
  wire             half;

  // One period is 2^(ratio+1) half steps; the shift count is widened so
  // ratio 7 does not wrap to zero. CNT_W below 8 cuts the top ratio.
  assign span     = {{CNT_W{1'b0}}, 1'b1} << ({1'b0, i_div} + 4'h1);
  assign span_m1  = span - 1'b1;
  assign last_pos = span_m1[CNT_W-1:0];
  assign half     = i_rise | i_fall;
  assign pos_now  = run_ff ? cnt_ff : {CNT_W{1'b0}};

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_out = out_ff;
    if (!i_enable) begin
      nxt_cnt = {CNT_W{1'b0}};
      nxt_run = 1'b0;
      nxt_out = 1'b0;
    end else if (!run_ff) begin
      // Start only on a source rising edge so the first pulse is whole
      if (i_rise) begin
        nxt_run = 1'b1;
        nxt_out = is_high(pos_now, i_div, i_duty);
        nxt_cnt = (last_pos == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} :
                  {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else if (half) begin
      nxt_out = is_high(pos_now, i_div, i_duty);
      nxt_cnt = (cnt_ff >= last_pos) ? {CNT_W{1'b0}} : cnt_ff + 1'b1;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= {CNT_W{1'b0}};
      run_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      out_ff <= nxt_out;
    end
  end

  assign o_clk_out = out_ff;
  assign o_running = run_ff;

endmodule

// File: rtl/rco_top.v
// Operation
// - Source codes 0 to 7 pick the system clock and the seven oscillators.
// - Enable starts the output on a source rising edge, with no short pulse.
// - Clearing enable drops the output at once, mid-period if need be.
// - The ratio field divides the source by two to its power, up to 128.
// - For nonzero ratios the duty field gives 75, 50, 25 or 0 percent high.
// - At ratio zero nonzero duty gives 50 percent and duty zero holds low.
// - The duty field resets to 10, giving a 50 percent default.
// - In sleep the output runs on for every source but the system clock.
// - The divided clock drives the pin and an internal clock output.
// - Control: enable bit 7 (reset 0), duty bits 4:3, ratio bits 2:0.
// - Bit 6 of the peripheral disable register holds the module off.
`timescale 1ns/1ps
`include "rco_map.vh"

module rco_top (
  input  wire        i_clk_sys,                 // System clock, 100 MHz
  input  wire        i_resetn,                  // Async reset, active low
  input  wire        i_sleep,                   // Device sleep level
  input  wire        i_high_freq_internal_osc,  // Source 1
  input  wire        i_low_freq_internal_osc,   // Source 2
  input  wire        i_mid_freq_internal_osc_h, // Source 3, 500 kHz
  input  wire        i_mid_freq_internal_osc_l, // Source 4, 32 kHz
  input  wire        i_secondary_osc,           // Source 5
  input  wire        i_external_osc,            // Source 6
  input  wire        i_numeric_osc_output,      // Source 7
  input  wire        i_logic_cell1_output,      // Source 8
  input  wire        i_logic_cell2_output,      // Source 9
  input  wire        i_logic_cell3_output,      // Source 10
  input  wire        i_logic_cell4_output,      // Source 11
  input  wire [11:0] i_avs_address,             // Byte address
  input  wire        i_avs_read,                // Read request
  input  wire        i_avs_write,               // Write request
  input  wire [31:0] i_avs_writedata,           // Write data
  input  wire [3:0]  i_avs_byteenable,          // Byte enables
  output wire [31:0] o_avs_readdata,            // Read data
  output wire        o_avs_waitrequest,         // Wait request
  output wire        o_refout_signal,           // Reference clock pin
  output wire        o_refclk_internal          // Internal clock tap
);

  // ----------------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------------
  localparam NSRC = 11;
  localparam [11:0] ADDR_PMD  = `RCO_IDX_PERIPH_OFF0 << 2;
  localparam [11:0] ADDR_CTRL = `RCO_IDX_CONTROL << 2;
  localparam [11:0] ADDR_SRC  = `RCO_IDX_SOURCE_SEL << 2;
  localparam [11:0] ADDR_STAT = `RCO_IDX_STATUS << 2;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  reg        en_ff;
  reg        nxt_en;
  reg  [1:0] duty_ff;
  reg  [1:0] nxt_duty;
  reg  [2:0] div_ff;
  reg  [2:0] nxt_div;
  reg  [3:0] src_ff;
  reg  [3:0] nxt_src;
  reg  [7:0] pmd_ff;
  reg  [7:0] nxt_pmd;
  reg        ack_ff;
  reg        nxt_ack;
  reg  [7:0] rdata_ff;
  reg  [7:0] nxt_rdata;

  // ----------------------------------------------------------------------
  // Source path
  // ----------------------------------------------------------------------
  wire [NSRC-1:0] src_raw;
  reg  [NSRC-1:0] sync1_ff;
  reg  [NSRC-1:0] sync2_ff;
  reg             sys_lvl_ff;
  reg             nxt_sys_lvl;
  reg             sleep1_ff;
  reg             sleep2_ff;
  reg             sel_prev_ff;
  reg             sel_lvl;
  wire            sel_rise;
  wire            sel_fall;
  wire            eff_enable;
  wire            div_out;
  wire            div_run;
  wire            halted;
  wire            bus_req;
  wire            wr_take;
  wire            wr_lane0;

  assign src_raw = {i_logic_cell4_output, i_logic_cell3_output,
                    i_logic_cell2_output, i_logic_cell1_output,
                    i_numeric_osc_output, i_external_osc,
                    i_secondary_osc, i_mid_freq_internal_osc_l,
                    i_mid_freq_internal_osc_h, i_low_freq_internal_osc,
                    i_high_freq_internal_osc};

  // Foreign clocks are only sampled; edges closer than one system
  // cycle apart cannot be resolved.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_ff  <= {NSRC{1'b0}};
      sync2_ff  <= {NSRC{1'b0}};
      sleep1_ff <= 1'b0;
      sleep2_ff <= 1'b0;
    end else begin
      sync1_ff  <= src_raw;
      sync2_ff  <= sync1_ff;
      sleep1_ff <= i_sleep;
      sleep2_ff <= sleep1_ff;
    end
  end

  // System clock source gives one half-period per cycle, so its fastest
  // output is half the system rate; it freezes during sleep.
  assign halted = sleep2_ff && (src_ff == `RCO_SRC_SYSOSC);

  always @* begin
    nxt_sys_lvl = sys_lvl_ff;
    if (!halted)
      nxt_sys_lvl = ~sys_lvl_ff;
  end

  always @* begin
    sel_lvl = 1'b0;
    if (src_ff == `RCO_SRC_SYSOSC)
      sel_lvl = sys_lvl_ff;
    else if (src_ff <= `RCO_SRC_LAST_VALID)
      sel_lvl = sync2_ff[src_ff - 4'h1];
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sys_lvl_ff  <= 1'b0;
      sel_prev_ff <= 1'b0;
    end else begin
      sys_lvl_ff  <= nxt_sys_lvl;
      sel_prev_ff <= sel_lvl;
    end
  end

  assign sel_rise = sel_lvl & ~sel_prev_ff;
  assign sel_fall = ~sel_lvl & sel_prev_ff;

  // ----------------------------------------------------------------------
  // Divider and outputs
  // ----------------------------------------------------------------------
  assign eff_enable = en_ff & ~pmd_ff[`RCO_PMD_OFF_BIT];

  rco_divider #(
    .CNT_W (8)
  ) u_div (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_enable  (eff_enable),
    .i_rise    (sel_rise),
    .i_fall    (sel_fall),
    .i_div     (div_ff),
    .i_duty    (duty_ff),
    .o_clk_out (div_out),
    .o_running (div_run)
  );

  assign o_refout_signal   = div_out;
  assign o_refclk_internal = div_out;

  // ----------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------
  // One wait cycle per access keeps read data registered.
  assign bus_req           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_ff;
  assign wr_take           = i_avs_write & ack_ff;
  assign wr_lane0          = wr_take & i_avs_byteenable[0];
  assign o_avs_readdata    = {24'h000000, rdata_ff};

  always @* begin
    nxt_ack = bus_req & ~ack_ff;
  end

  always @* begin
    nxt_rdata = rdata_ff;
    if (i_avs_read && !ack_ff) begin
      case (i_avs_address)
        ADDR_PMD:  nxt_rdata = pmd_ff;
        ADDR_CTRL: nxt_rdata = {en_ff, 2'b00, duty_ff, div_ff};
        ADDR_SRC:  nxt_rdata = {4'h0, src_ff};
        ADDR_STAT: nxt_rdata = {5'h00, halted, div_out, div_run};
        default:   nxt_rdata = 8'h00;
      endcase
    end
  end

  // Ratio and duty take effect at once even while running; software is
  // expected to change them only with the module disabled.
  always @* begin
    nxt_en   = en_ff;
    nxt_duty = duty_ff;
    nxt_div  = div_ff;
    nxt_src  = src_ff;
    nxt_pmd  = pmd_ff;
    if (wr_lane0) begin
      case (i_avs_address)
        ADDR_PMD: begin
          nxt_pmd = i_avs_writedata[7:0];
        end
        ADDR_CTRL: begin
          nxt_en   = i_avs_writedata[`RCO_CTRL_EN_BIT];
          nxt_duty = i_avs_writedata[`RCO_CTRL_DUTY_HI:`RCO_CTRL_DUTY_LO];
          nxt_div  = i_avs_writedata[`RCO_CTRL_DIV_HI:`RCO_CTRL_DIV_LO];
        end
        ADDR_SRC: begin
          nxt_src = i_avs_writedata[`RCO_SRC_HI:`RCO_SRC_LO];
        end
        default: begin
          nxt_src = src_ff;
        end
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      en_ff    <= `RCO_EN_RST;
      duty_ff  <= `RCO_DUTY_RST;
      div_ff   <= `RCO_DIV_RST;
      src_ff   <= `RCO_SRC_RST;
      pmd_ff   <= `RCO_PMD_RST;
      ack_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      en_ff    <= nxt_en;
      duty_ff  <= nxt_duty;
      div_ff   <= nxt_div;
      src_ff   <= nxt_src;
      pmd_ff   <= nxt_pmd;
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

endmodule

// File: tb/rco_top_asserts.sv
`timescale 1ns/1ps
module rco_top_asserts (
  input wire logic        i_clk_sys,         // System clock
  input wire logic        i_resetn,          // Async reset, active low
  input wire logic        i_sleep,           // Device sleep
  input wire logic [11:0] i_avs_address,     // Byte address
  input wire logic        i_avs_read,        // Read request
  input wire logic        i_avs_write,       // Write request
  input wire logic [31:0] i_avs_writedata,   // Write data
  input wire logic [3:0]  i_avs_byteenable,  // Byte enables
  input wire logic [31:0] o_avs_readdata,    // Read data
  input wire logic        o_avs_waitrequest, // Wait request
  input wire logic        o_refout_signal,   // Reference pin
  input wire logic        o_refclk_internal  // Internal tap
);
  // ---------------------------------------------------------------
  // Shadow of the registers, rebuilt from committed bus writes
  // ---------------------------------------------------------------
  logic [7:0] ctl_ff;
  logic [3:0] src_ff;
  logic       off_ff;
  logic [3:0] slp_ff;
  logic [3:0] age_ff;
  wire        wdo = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire        ctl_wr = wdo && i_avs_address == 12'ha58;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_ff <= 8'h10;
      src_ff <= 4'h0;
      off_ff <= 1'b0;
      slp_ff <= 4'h0;
      age_ff <= 4'h0;
    end else begin
      if (ctl_wr) ctl_ff <= i_avs_writedata[7:0];
      if (wdo && i_avs_address == 12'ha5c) src_ff <= i_avs_writedata[3:0];
      if (wdo && i_avs_address == 12'h430) off_ff <= i_avs_writedata[6];
      // Saturate so long sleeps and quiet spells do not wrap
      slp_ff <= !i_sleep ? 4'h0 : slp_ff + {3'h0, slp_ff != 4'hf};
      age_ff <= wdo ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_wait_one: assert property ($rose(i_avs_read | i_avs_write) |->
    o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait not one");
  a_wait_idle: assert property (!(i_avs_read | i_avs_write) |->
    !o_avs_waitrequest) else $error("wait without request");
  a_upper_zero: assert property (o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_tap_same: assert property (o_refclk_internal == o_refout_signal)
    else $error("internal tap differs from pin");
  a_stop_now: assert property (ctl_wr && !i_avs_writedata[7] |->
    ##2 !o_refout_signal [*3]) else $error("output not stopped");
  a_idle_low: assert property ((!ctl_ff[7] || off_ff) && age_ff >= 4'd3
    |-> !o_refout_signal) else $error("output while disabled");
  a_duty_zero: assert property (ctl_ff[4:3] == 2'b00 && age_ff >= 4'd6
    |-> !o_refout_signal) else $error("duty zero not low");
  a_div1_shape: assert property ($rose(o_refout_signal) &&
    ctl_ff == 8'h91 && src_ff == 4'h0 && !i_avs_write |=>
    o_refout_signal ##1 !o_refout_signal) else $error("bad div1 shape");
  a_undiv_toggle: assert property ($rose(o_refout_signal) &&
    ctl_ff == 8'h88 && src_ff == 4'h0 && !i_avs_write |=>
    !o_refout_signal ##1 o_refout_signal) else $error("bad undivided");
  a_sleep_hold: assert property (slp_ff >= 4'd5 && src_ff == 4'h0
    |-> $stable(o_refout_signal)) else $error("output moved in sleep");
  c_stop: cover property (ctl_wr && !i_avs_writedata[7] && o_refout_signal);
  c_sleep: cover property (slp_ff >= 4'd5 && src_ff == 4'h0);
  c_div1: cover property ($rose(o_refout_signal) && ctl_ff == 8'h91);
endmodule

bind rco_top rco_top_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_sleep(i_sleep),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_refout_signal(o_refout_signal), .o_refclk_internal(o_refclk_internal)
);

// File: tb/rco_src_model.sv
`timescale 1ns/1ps
module rco_src_model (
  output wire [11:1] o_src  // Free-running source clocks 1 to 11
);
  // ---------------------------------------------------------------
  // Each source has its own period, unrelated to the system clock
  // ---------------------------------------------------------------
  for (genvar k = 1; k < 12; k++) begin : g_osc
    logic s = 1'b0;
    always #(40 + 6 * k) s = ~s;
    assign o_src[k] = s;
  end
endmodule

// File: tb/reference_clock_output_test.sv
`timescale 1ns/1ps
`include "rco_map.vh"
module reference_clock_output_test;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sleep = 1'b0;
  logic [11:0] adr = 12'h000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         wreq;
  wire         ref_pin;
  wire         tap;
  wire  [11:1] src;
  int          n_fail = 0;
  int          total_checks = 0;
  localparam logic [11:0] A_OFF = `RCO_IDX_PERIPH_OFF0 << 2;
  localparam logic [11:0] A_CTL = `RCO_IDX_CONTROL << 2;
  localparam logic [11:0] A_SRC = `RCO_IDX_SOURCE_SEL << 2;
  localparam logic [11:0] A_STAT = `RCO_IDX_STATUS << 2;

  always #5 clk = ~clk;

  rco_src_model u_src (.o_src(src));
  rco_top u_dut (
    .i_clk_sys(clk), .i_resetn(resetn), .i_sleep(sleep),
    .i_high_freq_internal_osc(src[1]), .i_low_freq_internal_osc(src[2]),
    .i_mid_freq_internal_osc_h(src[3]), .i_mid_freq_internal_osc_l(src[4]),
    .i_secondary_osc(src[5]), .i_external_osc(src[6]),
    .i_numeric_osc_output(src[7]), .i_logic_cell1_output(src[8]),
    .i_logic_cell2_output(src[9]), .i_logic_cell3_output(src[10]),
    .i_logic_cell4_output(src[11]), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .o_refout_signal(ref_pin), .o_refclk_internal(tap));

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus access: hold everything until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    adr <= a;
    wdat <= {24'h0, d};
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic creg(input string n, input logic [11:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask

  task automatic hcount(input int n, output int h, output int r);
    logic p;
    h = 0;
    r = 0;
    p = ref_pin;
    repeat (n) begin
      @(posedge clk);
      if (ref_pin === 1'b1) h++;
      if (ref_pin === 1'b1 && p !== 1'b1) r++;
      p = ref_pin;
    end
  endtask

  task automatic wait_pin(input logic v);
    int k;
    k = 0;
    while (ref_pin !== v && k < 600) begin
      @(posedge clk);
      k++;
    end
    // A wait that runs out is counted as a mismatch
    if (k >= 600) chk("wait_pin", {31'h0, v}, {31'h0, ref_pin});
  endtask

  // Window is two whole periods, so the count is phase independent
  task automatic t_ratio(input int dv, input int dty);
    int n, h, r, e;
    n = 4 << dv;
    e = (dty == 0) ? 0 : (dv == 0) ? n / 2 : n * dty / 4;
    wreg(A_CTL, {3'b000, dty[1:0], dv[2:0]});
    wreg(A_CTL, {3'b100, dty[1:0], dv[2:0]});
    repeat (8) @(posedge clk);
    hcount(n, h, r);
    chk("high_cycles", e, h);
    chk("rises", (dty == 0) ? 0 : 2, r);
  endtask

  task automatic t_stop;
    int h;
    wreg(A_CTL, 8'h1b);
    wreg(A_CTL, 8'h9b);
    wait_pin(1'b1);
    chk("tap_high", 32'h1, {31'h0, tap});
    repeat (3) @(posedge clk);
    wreg(A_CTL, 8'h1b);
    @(posedge clk);
    chk("stop_now", 32'h0, {31'h0, ref_pin});
    wreg(A_CTL, 8'h9b);
    wait_pin(1'b1);
    h = 0;
    while (ref_pin === 1'b1 && h < 300) begin
      @(posedge clk);
      h++;
    end
    chk("first_high", 12, h);
  endtask

  task automatic t_off;
    int h, r;
    wreg(A_CTL, 8'h11);
    wreg(A_OFF, 8'h40);
    wreg(A_CTL, 8'h91);
    hcount(60, h, r);
    chk("off_quiet", 0, h);
    creg("ctl_kept", A_CTL, 32'h91);
    wreg(A_OFF, 8'h00);
    repeat (8) @(posedge clk);
    hcount(8, h, r);
    chk("resume", 4, h);
  endtask

  // Expected rises follow the model's source periods
  task automatic t_src(input int s, input int e);
    int h, r;
    wreg(A_CTL, 8'h11);
    wreg(A_SRC, s[7:0]);
    wreg(A_CTL, 8'h91);
    hcount(600, h, r);
    chk("src_rate", 1, r >= e - 1 && r <= e + 1);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #600000;
    n_fail++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    creg("control", A_CTL, 32'h10);
    creg("source", A_SRC, 32'h0);
    creg("periph_off", A_OFF, 32'h0);
    wreg(12'h004, 8'hff);
    creg("unmapped", 12'h004, 32'h0);
    for (int d = 0; d < 8; d++) t_ratio(d, 2);
    for (int c = 0; c < 4; c++) t_ratio(3, c);
    for (int c = 0; c < 4; c++) t_ratio(0, c);
    t_stop;
    t_off;
    for (int s = 1; s < 16; s++)
      t_src(s, s < 12 ? 6000 / (160 + 24 * s) : 0);
    sleep <= 1'b1;
    t_src(0, 0);
    creg("halted", A_STAT, 32'h4);
    t_src(5, 6000 / 280);
    sleep <= 1'b0;
    tally_and_finish;
  end
endmodule
